// ---- hw/sfc_cfg.svh ----
// Overview of operation
// - Watchdog divider select uses only its low three bits, ratios 1 to 128.
// - Watchdog counter overflow raises a reset request to the processor.
// - Status register is 8 bits: null, carry, half carry, overflow, halt, expired.
// - Software may alter only the carry, half carry, null and overflow status bits.
// - Data writes to status never change halt-entered or watchdog-expired.
// - Carry set by add carry-out or subtract without borrow, else cleared.
// - Rotate-through-carry instructions rotate through and update the carry flag.
// - Half carry set by low-nibble carry or no low-nibble borrow, else cleared.
// - Null flag set when arithmetic or logical result is zero, else cleared.
// - Overflow flag set when carry into and out of bit 7 differ.
// - Halt-entered cleared by power-up or kick, set by halt, nothing else.
// - Watchdog-expired cleared by power-up, kick instruction or halt.
// - Watchdog-expired set by time-out; no other event sets it.
// - Interrupt entry and calls never save the status register.
// - Separate enable bits for external and each timer interrupt.
// - Global enable clear blocks every intTake source regardless of individual enables; irq is not gated by it.
// - Global enable cleared on interrupt entry, set by interrupt return.
// - Software may set global enable inside a service routine for nesting.
`ifndef SFC_CFG_SVH
`define SFC_CFG_SVH

`define SFC_ADDR_WDIV   8'h09
`define SFC_ADDR_FLAGS  8'h0a
`define SFC_ADDR_ICL    8'h0b
`define SFC_ADDR_ICH    8'h1e
`define SFC_ADDR_EVST   8'h40
`define SFC_ADDR_EVCLR  8'h41
`define SFC_ADDR_EVEN   8'h42

`define SFC_FLG_C       0
`define SFC_FLG_AC      1
`define SFC_FLG_Z       2
`define SFC_FLG_OV      3
`define SFC_FLG_PDF     4
`define SFC_FLG_TO      5
`define SFC_FLG_SW_MASK 8'h0f

`define SFC_ICL_GIE     0
`define SFC_ICL_EXT     1
`define SFC_ICL_T0      2
`define SFC_ICL_T1      3
`define SFC_ICH_T2      0
`define SFC_ICH_T3      1

`define SFC_EV_WDT      0
`define SFC_EV_HALT     1
`define SFC_EV_INT      2
`define SFC_EV_W        3

`define SFC_SRC_EXT     0
`define SFC_SRC_T0      1
`define SFC_SRC_T1      2
`define SFC_SRC_T2      3
`define SFC_SRC_T3      4
`define SFC_SRC_W       5

`define SFC_RST_WDIV    8'h07
`define SFC_RST_FLAGS   8'h00
`define SFC_RST_ICL     8'h00
`define SFC_RST_ICH     8'h00
`define SFC_RST_EV      3'h0

`define SFC_WDIV_SEL_W  3
`define SFC_WDT_PRE_W   7
`define SFC_WDT_CNT_W   8

`endif

// ---- hw/sfc_pkg.sv ----
package sfc_pkg;

    typedef enum logic [3:0] {
        OP_NONE,
        OP_ADD,
        OP_ADC,
        OP_SUB,
        OP_SBC,
        OP_INC,
        OP_DEC,
        OP_AND,
        OP_OR,
        OP_XOR,
        OP_CPL,
        OP_RLC,
        OP_RRC,
        OP_RL,
        OP_RR
    } sfc_op_t;

    typedef struct packed {
        sfc_op_t    op;
        logic [7:0] a;
        logic [7:0] b;
    } sfc_alu_req_t;

    typedef struct packed {
        logic ov;
        logic z;
        logic ac;
        logic c;
    } sfc_arith_flags_t;

    typedef struct packed {
        logic [7:0]       res;
        sfc_arith_flags_t flags;
        sfc_arith_flags_t upd;
    } sfc_alu_res_t;

    typedef struct packed {
        logic halt;
        logic kick;
        logic intEntry;
        logic intReturn;
    } sfc_ctrl_evt_t;

endpackage

// ---- hw/sfc_alu_flags.sv ----
`timescale 1ns/1ns
`include "sfc_cfg.svh"

module sfc_alu_flags (
    input  wire sfc_pkg::sfc_alu_req_t  req,
    input  wire logic                   carryIn,
    output      sfc_pkg::sfc_alu_res_t  out
);

    logic [8:0] sum;
    logic [4:0] lowSum;
    logic [7:0] bOp;
    logic       cin;
    logic       arith;

    always_comb begin
        bOp    = req.b;
        cin    = 1'b0;
        arith  = 1'b0;
        out    = '0;
        unique case (req.op)
            sfc_pkg::OP_ADD: begin
                arith = 1'b1;
            end
            sfc_pkg::OP_ADC: begin
                arith = 1'b1;
                cin   = carryIn;
            end
            sfc_pkg::OP_SUB: begin
                arith = 1'b1;
                bOp   = ~req.b;
                cin   = 1'b1;
            end
            sfc_pkg::OP_SBC: begin
                arith = 1'b1;
                bOp   = ~req.b;
                cin   = carryIn;
            end
            default: begin
            end
        endcase
        // Subtract as a + ~b + cin: carry out means no borrow
        sum    = {1'b0, req.a} + {1'b0, bOp} + {8'h00, cin};
        lowSum = {1'b0, req.a[3:0]} + {1'b0, bOp[3:0]} + {4'h0, cin};
        unique case (req.op)
            sfc_pkg::OP_NONE: out.res = req.a;
            sfc_pkg::OP_INC:  out.res = req.a + 8'h01;
            sfc_pkg::OP_DEC:  out.res = req.a - 8'h01;
            sfc_pkg::OP_AND:  out.res = req.a & req.b;
            sfc_pkg::OP_OR:   out.res = req.a | req.b;
            sfc_pkg::OP_XOR:  out.res = req.a ^ req.b;
            sfc_pkg::OP_CPL:  out.res = ~req.a;
            sfc_pkg::OP_RLC:  out.res = {req.a[6:0], carryIn};
            sfc_pkg::OP_RRC:  out.res = {carryIn, req.a[7:1]};
            sfc_pkg::OP_RL:   out.res = {req.a[6:0], req.a[7]};
            sfc_pkg::OP_RR:   out.res = {req.a[0], req.a[7:1]};
            default:          out.res = sum[7:0];
        endcase
        out.flags.c  = sum[8];
        out.flags.ac = lowSum[4];
        out.flags.ov = (req.a[7] ^ bOp[7] ^ sum[7]) ^ sum[8];
        out.flags.z  = (out.res == 8'h00);
        if (req.op == sfc_pkg::OP_RLC) begin
            out.flags.c = req.a[7];
        end else if (req.op == sfc_pkg::OP_RRC) begin
            out.flags.c = req.a[0];
        end
        out.upd.c  = arith || req.op == sfc_pkg::OP_RLC || req.op == sfc_pkg::OP_RRC;
        out.upd.ac = arith;
        out.upd.ov = arith;
        out.upd.z  = arith || (req.op inside {sfc_pkg::OP_INC, sfc_pkg::OP_DEC,
                     sfc_pkg::OP_AND, sfc_pkg::OP_OR, sfc_pkg::OP_XOR, sfc_pkg::OP_CPL});
    end

endmodule

// ---- hw/sfc_watchdog.sv ----
`timescale 1ns/1ns
`include "sfc_cfg.svh"

module sfc_watchdog #(
    parameter int PRE_W = `SFC_WDT_PRE_W,
    parameter int CNT_W = `SFC_WDT_CNT_W
) (
    input  wire logic                        clk,
    input  wire logic                        srst,
    input  wire logic [`SFC_WDIV_SEL_W-1:0]  divSel,
    input  wire logic                        kick,
    output      logic                        timeout
);

    logic [PRE_W-1:0] pre_q;
    logic [PRE_W-1:0] pre_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             tick;

    function automatic logic [PRE_W-1:0] divMask(input logic [`SFC_WDIV_SEL_W-1:0] sel);
        logic [PRE_W-1:0] m;
        m = '0;
        for (int i = 0; i < PRE_W; i++) begin
            m[i] = (i < int'(sel));
        end
        return m;
    endfunction

    always_comb begin
        // Ratio is two to the power of the select, 1 up to 128
        tick    = ((pre_q & divMask(divSel)) == divMask(divSel));
        pre_d   = pre_q + {{(PRE_W-1){1'b0}}, 1'b1};
        cnt_d   = cnt_q;
        timeout = tick && (cnt_q == {CNT_W{1'b1}});
        if (tick) begin
            cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end
        if (kick) begin
            pre_d = '0;
            cnt_d = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pre_q <= '0;
            cnt_q <= '0;
        end else begin
            pre_q <= pre_d;
            cnt_q <= cnt_d;
        end
    end

endmodule

// ---- hw/sfc_top.sv ----
`timescale 1ns/1ns
`include "sfc_cfg.svh"

module sfc_top #(
    parameter int WDT_CNT_W = `SFC_WDT_CNT_W
) (
    input  wire logic                      clk,
    input  wire logic                      srst,
    input  wire logic [7:0]                regAddr,
    input  wire logic [7:0]                regWdata,
    input  wire logic                      regWr,
    input  wire logic                      regRd,
    output      logic [7:0]                regRdata,
    input  wire sfc_pkg::sfc_alu_req_t     aluReq,
    output      logic [7:0]                aluResult,
    input  wire sfc_pkg::sfc_ctrl_evt_t    ctrlEvt,
    input  wire logic [`SFC_SRC_W-1:0]     intSrcReq,
    output      logic                      intTake,
    output      logic                      wdtReset,
    output      logic [7:0]                flagsOut,
    output      logic                      irq
);

    logic [7:0]             wdiv_q;
    logic [7:0]             wdiv_d;
    logic [7:0]             flags_q;
    logic [7:0]             flags_d;
    logic [7:0]             icl_q;
    logic [7:0]             icl_d;
    logic [7:0]             ich_q;
    logic [7:0]             ich_d;
    logic [`SFC_EV_W-1:0]   evSt_q;
    logic [`SFC_EV_W-1:0]   evSt_d;
    logic [`SFC_EV_W-1:0]   evEn_q;
    logic [`SFC_EV_W-1:0]   evEn_d;
    logic [7:0]             rdata_q;
    logic [7:0]             rdata_d;
    logic [7:0]             aluRes_q;
    logic [7:0]             aluRes_d;
    logic                   wdtRst_q;
    logic                   wdtRst_d;
    logic                   timeout;
    logic [`SFC_EV_W-1:0]   evSet;
    logic [`SFC_EV_W-1:0]   evClr;
    logic [`SFC_SRC_W-1:0]  srcEn;
    sfc_pkg::sfc_alu_res_t  alu;

    function automatic logic wrHit(input logic [7:0] a);
        return regWr && (regAddr == a);
    endfunction

    sfc_alu_flags u_alu (
        .req     (aluReq),
        .carryIn (flags_q[`SFC_FLG_C]),
        .out     (alu)
    );

    sfc_watchdog #(
        .PRE_W (`SFC_WDT_PRE_W),
        .CNT_W (WDT_CNT_W)
    ) u_wdt (
        .clk     (clk),
        .srst    (srst),
        .divSel  (wdiv_q[`SFC_WDIV_SEL_W-1:0]),
        .kick    (ctrlEvt.kick),
        .timeout (timeout)
    );

    // Divider select register
    always_comb begin
        wdiv_d = wdiv_q;
        if (wrHit(`SFC_ADDR_WDIV)) begin
            wdiv_d = regWdata;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wdiv_q <= `SFC_RST_WDIV;
        end else begin
            wdiv_q <= wdiv_d;
        end
    end

    // Processor flags
    always_comb begin
        flags_d  = flags_q;
        aluRes_d = aluRes_q;
        if (aluReq.op != sfc_pkg::OP_NONE) begin
            aluRes_d = alu.res;
            if (alu.upd.c) begin
                flags_d[`SFC_FLG_C] = alu.flags.c;
            end
            if (alu.upd.ac) begin
                flags_d[`SFC_FLG_AC] = alu.flags.ac;
            end
            if (alu.upd.z) begin
                flags_d[`SFC_FLG_Z] = alu.flags.z;
            end
            if (alu.upd.ov) begin
                flags_d[`SFC_FLG_OV] = alu.flags.ov;
            end
        end
        // Software write only reaches the arithmetic bits
        if (wrHit(`SFC_ADDR_FLAGS)) begin
            flags_d = (flags_d & ~`SFC_FLG_SW_MASK)
                    | (regWdata & `SFC_FLG_SW_MASK);
        end
        if (ctrlEvt.halt) begin
            flags_d[`SFC_FLG_PDF] = 1'b1;
        end else if (ctrlEvt.kick) begin
            flags_d[`SFC_FLG_PDF] = 1'b0;
        end
        if (timeout) begin
            flags_d[`SFC_FLG_TO] = 1'b1;
        end else if (ctrlEvt.kick || ctrlEvt.halt) begin
            flags_d[`SFC_FLG_TO] = 1'b0;
        end
        // Interrupt entry leaves the flags alone
        if (ctrlEvt.intEntry) begin
            flags_d = flags_d;
        end
        flags_d[7:6] = 2'b00;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            flags_q  <= `SFC_RST_FLAGS;
            aluRes_q <= 8'h00;
        end else begin
            flags_q  <= flags_d;
            aluRes_q <= aluRes_d;
        end
    end

    // Interrupt control registers
    always_comb begin
        icl_d = icl_q;
        ich_d = ich_q;
        if (ctrlEvt.intReturn) begin
            icl_d[`SFC_ICL_GIE] = 1'b1;
        end
        if (wrHit(`SFC_ADDR_ICL)) begin
            icl_d = regWdata;
        end
        if (wrHit(`SFC_ADDR_ICH)) begin
            ich_d = regWdata;
        end
        if (ctrlEvt.intEntry) begin
            icl_d[`SFC_ICL_GIE] = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            icl_q <= `SFC_RST_ICL;
            ich_q <= `SFC_RST_ICH;
        end else begin
            icl_q <= icl_d;
            ich_q <= ich_d;
        end
    end

    always_comb begin
        srcEn                = '0;
        srcEn[`SFC_SRC_EXT]  = icl_q[`SFC_ICL_EXT];
        srcEn[`SFC_SRC_T0]   = icl_q[`SFC_ICL_T0];
        srcEn[`SFC_SRC_T1]   = icl_q[`SFC_ICL_T1];
        srcEn[`SFC_SRC_T2]   = ich_q[`SFC_ICH_T2];
        srcEn[`SFC_SRC_T3]   = ich_q[`SFC_ICH_T3];
        intTake = icl_q[`SFC_ICL_GIE] && |(intSrcReq & srcEn);
    end

    // Event status, enable and clear
    always_comb begin
        evSet              = '0;
        evSet[`SFC_EV_WDT]  = timeout;
        evSet[`SFC_EV_HALT] = ctrlEvt.halt;
        evSet[`SFC_EV_INT]  = ctrlEvt.intEntry;
        evClr  = wrHit(`SFC_ADDR_EVCLR) ? regWdata[`SFC_EV_W-1:0] : '0;
        // A new event outranks a clear in the same cycle
        evSt_d = (evSt_q & ~evClr) | evSet;
        evEn_d = evEn_q;
        if (wrHit(`SFC_ADDR_EVEN)) begin
            evEn_d = regWdata[`SFC_EV_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            evSt_q <= `SFC_RST_EV;
            evEn_q <= `SFC_RST_EV;
        end else begin
            evSt_q <= evSt_d;
            evEn_q <= evEn_d;
        end
    end

    // Watchdog reset pulse
    always_comb begin
        wdtRst_d = timeout;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wdtRst_q <= 1'b0;
        end else begin
            wdtRst_q <= wdtRst_d;
        end
    end

    // Read port
    always_comb begin
        rdata_d = 8'h00;
        if (regRd) begin
            unique case (regAddr)
                `SFC_ADDR_WDIV:  rdata_d = wdiv_q;
                `SFC_ADDR_FLAGS: rdata_d = flags_q;
                `SFC_ADDR_ICL:   rdata_d = icl_q;
                `SFC_ADDR_ICH:   rdata_d = ich_q;
                `SFC_ADDR_EVST:  rdata_d = {{(8-`SFC_EV_W){1'b0}}, evSt_q};
                `SFC_ADDR_EVEN:  rdata_d = {{(8-`SFC_EV_W){1'b0}}, evEn_q};
                default:         rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign regRdata  = rdata_q;
    assign aluResult = aluRes_q;
    assign wdtReset  = wdtRst_q;
    assign flagsOut  = flags_q;
    assign irq       = |(evSt_q & evEn_q);

endmodule

// ---- verification/sfc_monitor.sv ----
`timescale 1ns/1ns
`include "sfc_cfg.svh"

module sfc_monitor #(
    parameter int WDT_CNT_W = `SFC_WDT_CNT_W
) (
    input wire logic                   clk,
    input wire logic                   srst,
    input wire logic [7:0]             regAddr,
    input wire logic [7:0]             regWdata,
    input wire logic                   regWr,
    input wire logic                   regRd,
    input wire logic [7:0]             regRdata,
    input wire sfc_pkg::sfc_alu_req_t  aluReq,
    input wire logic [7:0]             aluResult,
    input wire sfc_pkg::sfc_ctrl_evt_t ctrlEvt,
    input wire logic [`SFC_SRC_W-1:0]  intSrcReq,
    input wire logic                   intTake,
    input wire logic                   wdtReset,
    input wire logic [7:0]             flagsOut,
    input wire logic                   irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence sFlagWr;
        regWr && regAddr == `SFC_ADDR_FLAGS;
    endsequence

    sequence sQuietWr;
        sFlagWr ##0 (!ctrlEvt.halt && !ctrlEvt.kick);
    endsequence

    // A coinciding time-out wins and shows as wdtReset
    AST_HALT_SETS: assert property (ctrlEvt.halt |=> flagsOut[4] && (!flagsOut[5] || wdtReset))
        else $error("halt did not set halt flag or clear expiry flag");
    AST_KICK_CLEARS: assert property (ctrlEvt.kick && !ctrlEvt.halt |=> !flagsOut[4] && (!flagsOut[5] || wdtReset))
        else $error("kick did not clear halt and expiry flags");
    AST_HALT_ONLY: assert property (!ctrlEvt.halt && !ctrlEvt.kick |=> $stable(flagsOut[4]))
        else $error("halt flag changed without halt or kick");
    AST_TO_ON_OVF: assert property (wdtReset |-> flagsOut[5])
        else $error("watchdog reset without expiry flag");
    AST_TO_RISE: assert property ($rose(flagsOut[5]) |-> wdtReset)
        else $error("expiry flag rose without time-out");
    AST_WDT_PULSE: assert property (wdtReset |=> !wdtReset)
        else $error("watchdog reset longer than one cycle");
    AST_FLAG_WR: assert property (sFlagWr |=> flagsOut[3:0] == $past(regWdata[3:0]))
        else $error("flag write not taken");
    AST_FLAG_WR_KEEP: assert property (sQuietWr ##1 !wdtReset |-> $stable(flagsOut[5]))
        else $error("flag write changed expiry flag");
    AST_ADD: assert property (aluReq.op == sfc_pkg::OP_ADD && !(regWr && regAddr == `SFC_ADDR_FLAGS)
        |=> {flagsOut[0], aluResult} == $past(aluReq.a) + $past(aluReq.b)
        && flagsOut[2] == (aluResult == 8'h00))
        else $error("add result or carry or null flag wrong");
    AST_ENTRY_NO_SAVE: assert property (ctrlEvt.intEntry && !regWr && aluReq.op == sfc_pkg::OP_NONE
        |=> $stable(flagsOut[3:0]))
        else $error("interrupt entry touched flags");
    AST_ENTRY_GIE: assert property (ctrlEvt.intEntry |=> !intTake)
        else $error("interrupt taken after entry");
    AST_UNUSED: assert property (flagsOut[7:6] == 2'h0)
        else $error("unused flag bits set");
endmodule

bind sfc_top sfc_monitor #(.WDT_CNT_W(WDT_CNT_W)) u_mon (
    .clk, .srst, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .aluReq, .aluResult,
    .ctrlEvt, .intSrcReq, .intTake, .wdtReset, .flagsOut, .irq);

// ---- verification/tb.sv ----
`timescale 1ns/1ns
`include "sfc_cfg.svh"

module tb;
    logic                   clk;
    logic                   srst;
    logic [7:0]             regAddr;
    logic [7:0]             regWdata;
    logic                   regWr;
    logic                   regRd;
    logic [7:0]             regRdata;
    sfc_pkg::sfc_alu_req_t  aluReq;
    logic [7:0]             aluResult;
    sfc_pkg::sfc_ctrl_evt_t ctrlEvt;
    logic [4:0]             intSrcReq;
    logic                   intTake;
    logic                   wdtReset;
    logic [7:0]             flagsOut;
    logic                   irq;
    int                     mismatches;
    int                     n_tests;

    sfc_top #(.WDT_CNT_W(4)) u_dut (.clk, .srst, .regAddr, .regWdata, .regWr, .regRd,
        .regRdata, .aluReq, .aluResult, .ctrlEvt, .intSrcReq, .intTake, .wdtReset,
        .flagsOut, .irq);

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        chk8(regRdata, e);
    endtask

    task automatic evt(input sfc_pkg::sfc_ctrl_evt_t e);
        @(posedge clk);
        ctrlEvt <= e;
        @(posedge clk);
        ctrlEvt <= '0;
        #1;
    endtask

    // Flags are preset so the carry input and untouched bits are known
    task automatic alu(input sfc_pkg::sfc_op_t op, input logic [7:0] a, input logic [7:0] b,
                       input logic [3:0] fin, input logic [7:0] res, input logic [3:0] fout);
        wr(`SFC_ADDR_FLAGS, {4'h0, fin});
        @(posedge clk);
        aluReq <= '{op: op, a: a, b: b};
        @(posedge clk);
        aluReq.op <= sfc_pkg::OP_NONE;
        #1;
        chk8(aluResult, res);
        chk8({4'h0, flagsOut[3:0]}, {4'h0, fout});
    endtask

    // Period measured between two pulses, so the counter phase does not matter
    task automatic wdtPeriod(input logic [7:0] sel, input logic [7:0] exp);
        int n;
        wr(`SFC_ADDR_WDIV, sel);
        n = 0;
        while (wdtReset !== 1'b1) begin
            @(posedge clk);
            #1;
            n++;
            if (n > 4096) begin
                mismatches++;
                tally_and_finish();
            end
        end
        chk8({7'h00, flagsOut[5]}, 8'h01);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (wdtReset !== 1'b1 && n < 300);
        if (n >= 300) begin
            mismatches++;
            tally_and_finish();
        end
        chk8(n[7:0], exp);
    endtask

    sfc_pkg::sfc_ctrl_evt_t evHalt;
    sfc_pkg::sfc_ctrl_evt_t evKick;
    sfc_pkg::sfc_ctrl_evt_t evEntry;
    sfc_pkg::sfc_ctrl_evt_t evRet;

    initial begin
        logic [7:0] enL;
        logic [7:0] enH;
        logic [7:0] fl;
        srst = 1'b1;
        regAddr = 8'h00;
        regWdata = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        aluReq = '0;
        ctrlEvt = '0;
        intSrcReq = 5'h00;
        mismatches = 0;
        n_tests = 0;
        evHalt = '{halt: 1'b1, default: 1'b0};
        evKick = '{kick: 1'b1, default: 1'b0};
        evEntry = '{intEntry: 1'b1, default: 1'b0};
        evRet = '{intReturn: 1'b1, default: 1'b0};
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        rd(`SFC_ADDR_WDIV, 8'h07);
        rd(`SFC_ADDR_FLAGS, 8'h00);
        rd(`SFC_ADDR_ICL, 8'h00);
        rd(`SFC_ADDR_ICH, 8'h00);
        rd(8'h3f, 8'h00);
        $display("test reset values done");
        alu(sfc_pkg::OP_ADD, 8'h80, 8'h80, 4'h0, 8'h00, 4'hd);
        alu(sfc_pkg::OP_ADD, 8'h0f, 8'h01, 4'h0, 8'h10, 4'h2);
        alu(sfc_pkg::OP_ADC, 8'h7f, 8'h00, 4'h1, 8'h80, 4'ha);
        alu(sfc_pkg::OP_SUB, 8'h05, 8'h03, 4'h0, 8'h02, 4'h3);
        alu(sfc_pkg::OP_SUB, 8'h03, 8'h05, 4'hf, 8'hfe, 4'h0);
        alu(sfc_pkg::OP_SBC, 8'h05, 8'h05, 4'h1, 8'h00, 4'h7);
        alu(sfc_pkg::OP_INC, 8'hff, 8'h00, 4'hb, 8'h00, 4'hf);
        alu(sfc_pkg::OP_AND, 8'hf0, 8'h0f, 4'h1, 8'h00, 4'h5);
        alu(sfc_pkg::OP_XOR, 8'haa, 8'h55, 4'h4, 8'hff, 4'h0);
        alu(sfc_pkg::OP_RLC, 8'h80, 8'h00, 4'h0, 8'h00, 4'h1);
        alu(sfc_pkg::OP_RRC, 8'h02, 8'h00, 4'h1, 8'h81, 4'h0);
        alu(sfc_pkg::OP_RL, 8'h81, 8'h00, 4'hf, 8'h03, 4'hf);
        alu(sfc_pkg::OP_DEC, 8'h01, 8'h00, 4'h0, 8'h00, 4'h4);
        alu(sfc_pkg::OP_OR, 8'h12, 8'h21, 4'h4, 8'h33, 4'h0);
        alu(sfc_pkg::OP_CPL, 8'hff, 8'h00, 4'h3, 8'h00, 4'h7);
        alu(sfc_pkg::OP_RR, 8'h01, 8'h00, 4'h5, 8'h80, 4'h5);
        $display("test alu flags done");
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            intSrcReq <= 5'h01 << i;
            enL = (i < 3) ? (8'h02 << i) : 8'h00;
            enH = (i >= 3) ? (8'h01 << (i - 3)) : 8'h00;
            wr(`SFC_ADDR_ICH, enH);
            wr(`SFC_ADDR_ICL, enL);
            chk8({7'h00, intTake}, 8'h00);
            wr(`SFC_ADDR_ICL, enL | 8'h01);
            chk8({7'h00, intTake}, 8'h01);
        end
        fl = flagsOut;
        evt(evEntry);
        chk8({7'h00, intTake}, 8'h00);
        chk8(flagsOut, fl);
        wr(`SFC_ADDR_ICL, 8'h01);
        chk8({7'h00, intTake}, 8'h01);
        evt(evEntry);
        evt(evRet);
        chk8({7'h00, intTake}, 8'h01);
        rd(`SFC_ADDR_ICL, 8'h01);
        $display("test interrupt enables done");
        wdtPeriod(8'hf8, 8'h10);
        wdtPeriod(8'h0b, 8'h80);
        wr(`SFC_ADDR_WDIV, 8'h07);
        evt(evHalt);
        chk8({6'h00, flagsOut[5:4]}, 8'h01);
        wr(`SFC_ADDR_FLAGS, 8'hef);
        chk8(flagsOut, 8'h1f);
        evt(evKick);
        chk8(flagsOut, 8'h0f);
        rd(`SFC_ADDR_FLAGS, 8'h0f);
        $display("test watchdog and halt done");
        rd(`SFC_ADDR_EVST, 8'h07);
        wr(`SFC_ADDR_EVCLR, 8'h07);
        rd(`SFC_ADDR_EVST, 8'h00);
        wr(`SFC_ADDR_EVEN, 8'h02);
        chk8({7'h00, irq}, 8'h00);
        evt(evHalt);
        chk8({7'h00, irq}, 8'h01);
        wr(`SFC_ADDR_EVEN, 8'h00);
        chk8({7'h00, irq}, 8'h00);
        wr(`SFC_ADDR_EVEN, 8'h02);
        chk8({7'h00, irq}, 8'h01);
        wr(`SFC_ADDR_EVCLR, 8'h02);
        chk8({7'h00, irq}, 8'h00);
        rd(`SFC_ADDR_EVCLR, 8'h00);
        rd(`SFC_ADDR_EVEN, 8'h02);
        $display("test event interrupt done");
        tally_and_finish();
    end
endmodule
